// >>> hw/ims_pkg.sv
/*
 * Shared constants and types of the two-wire bus master sequencer.
 * Assumes a single instruction clock; no other package is needed.
 */
package ims_pkg;

    localparam int BAUD_W = 12;
    localparam int DATA_W = 8;
    localparam int CTRL_W = 5;

    // Event codes of the low control bits, one-hot
    localparam logic [CTRL_W-1:0] EV_NONE    = 5'h00;
    localparam logic [CTRL_W-1:0] EV_START   = 5'h01;
    localparam logic [CTRL_W-1:0] EV_RESTART = 5'h02;
    localparam logic [CTRL_W-1:0] EV_STOP    = 5'h04;
    localparam logic [CTRL_W-1:0] EV_RECEIVE = 5'h08;
    localparam logic [CTRL_W-1:0] EV_ACK     = 5'h10;

    // Baud counter step per instruction cycle
    localparam logic [BAUD_W-1:0] BAUD_STEP = 12'h002;

    // Bit counts: eight data bits, plus the acknowledge slot on transmit
    localparam logic [3:0] TX_LAST_BIT = 4'h8;
    localparam logic [3:0] RX_LAST_BIT = 4'h7;

    // Values after reset
    localparam logic [BAUD_W-1:0] BAUD_RST = 12'h000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [3:0]        BIT_RST  = 4'h0;
    localparam logic [1:0]        PH_RST   = 2'h0;
    localparam logic [1:0]        SYNC_RST = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_RESTART,
        ST_STOP,
        ST_TX,
        ST_RX,
        ST_ACK
    } ims_state_t;

endpackage : ims_pkg

// >>> hw/ims_baud_gen.sv
/*
 * Baud counter with clock-line synchronisation for the bus master.
 * Assumes i_scl_high is already synchronised to i_mclk.
 */
`timescale 1ns/1ps
module ims_baud_gen (
    // Clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst_n,
    // Control
    input  wire logic                      i_run,
    input  wire logic                      i_released,
    input  wire logic                      i_scl_high,
    input  wire logic [ims_pkg::BAUD_W-1:0] i_reload,
    // Status
    output logic                           o_tick,
    output logic                           o_stalled
);

    typedef struct packed {
        logic [ims_pkg::BAUD_W-1:0] cnt;
        logic                       stalled;
    } ims_baud_t;

    ims_baud_t st_reg;
    ims_baud_t st_next;

    always_comb
    begin
        st_next = st_reg;
        o_tick  = 1'b0;
        if (!i_run)
        begin
            st_next.cnt     = i_reload;
            st_next.stalled = 1'b0;
        end
        else if (i_released && !i_scl_high)
        begin
            // Line still held low by someone: freeze the count
            st_next.stalled = 1'b1;
        end
        else if (st_reg.stalled)
        begin
            // Line seen high: full high time guaranteed
            st_next.stalled = 1'b0;
            st_next.cnt     = i_reload;
        end
        else if (st_reg.cnt < ims_pkg::BAUD_STEP)
        begin
            o_tick      = 1'b1;
            st_next.cnt = i_reload;
        end
        else
        begin
            st_next.cnt = st_reg.cnt - ims_pkg::BAUD_STEP;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_reg <= '{cnt: ims_pkg::BAUD_RST, stalled: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_stalled = st_reg.stalled;

    a_hold_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_run && i_released && !i_scl_high |-> !o_tick ##1 o_stalled)
        else $error("counter not held while clock line low");

    a_reload_high: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_run && o_stalled && i_scl_high |=>
        st_reg.cnt == $past(i_reload) && !o_stalled)
        else $error("counter not reloaded after line high");

    a_count_step: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_run && !i_released && !o_stalled && !o_tick |=>
        st_reg.cnt == $past(st_reg.cnt) - ims_pkg::BAUD_STEP)
        else $error("counter did not step by two");

endmodule : ims_baud_gen

// >>> hw/ims_master.sv
/*
 * Two-wire bus master sequencer: start, restart, stop, byte transmit,
 * byte receive and acknowledge events, each launched by software.
 * Assumes open-drain pins outside; pin inputs are asynchronous.
 */
`timescale 1ns/1ps
module ims_master (
    // Clock and reset
    input  wire logic                       i_mclk,
    input  wire logic                       i_rst_n,
    // Control bits
    input  wire logic                       i_ctrl_we,
    input  wire logic [ims_pkg::CTRL_W-1:0] i_ctrl_bits,
    input  wire logic                       i_ack_level_select,
    input  wire logic [ims_pkg::BAUD_W-1:0] i_baud_reload_reg,
    output logic      [ims_pkg::CTRL_W-1:0] o_control_bits,
    output logic                            o_master_tx_active,
    // Data
    input  wire logic                       i_tx_we,
    input  wire logic [ims_pkg::DATA_W-1:0] i_tx_data_reg,
    input  wire logic                       i_rx_read,
    output logic      [ims_pkg::DATA_W-1:0] o_rx_data_reg,
    output logic                            o_rx_buffer_full,
    output logic                            o_ack_received,
    output logic                            o_master_event_irq,
    // Bus pins
    input  wire logic                       i_bus_clock_line,
    output logic                            o_bus_clock_line,
    output logic                            o_bus_clock_oe,
    input  wire logic                       i_bus_data_line,
    output logic                            o_bus_data_line,
    output logic                            o_bus_data_oe
);

    typedef struct packed {
        ims_pkg::ims_state_t        st;
        logic [1:0]                 ph;
        logic [3:0]                 bitn;
        logic [ims_pkg::DATA_W-1:0] shift;
        logic [ims_pkg::DATA_W-1:0] rx;
        logic                       rx_buffer_full;
        logic                       irq;
        logic                       ackd;
        logic                       scl_low;
        logic                       sda_low;
        logic [1:0]                 scl_s;
        logic [1:0]                 sda_s;
    } ims_master_t;

    ims_master_t r_reg;
    ims_master_t r_next;
    logic        tick;
    logic        stalled;

    // Declared ahead of the next-state logic that reads them
    localparam logic [1:0] PH_ONE  = 2'h1;
    localparam logic [3:0] RX_BIT7 = ims_pkg::RX_LAST_BIT;

    function automatic logic [ims_pkg::CTRL_W-1:0] ev_code(
        input ims_pkg::ims_state_t s);
        unique case (s)
            ims_pkg::ST_START:   ev_code = ims_pkg::EV_START;
            ims_pkg::ST_RESTART: ev_code = ims_pkg::EV_RESTART;
            ims_pkg::ST_STOP:    ev_code = ims_pkg::EV_STOP;
            ims_pkg::ST_RX:      ev_code = ims_pkg::EV_RECEIVE;
            ims_pkg::ST_ACK:     ev_code = ims_pkg::EV_ACK;
            default:             ev_code = ims_pkg::EV_NONE;
        endcase
    endfunction : ev_code

    // Runs outside ST_IDLE; there is no switch to turn synchronisation off
    ims_baud_gen u_baud (
        .i_mclk     (i_mclk),
        .i_rst_n    (i_rst_n),
        .i_run      (r_reg.st != ims_pkg::ST_IDLE),
        .i_released (!r_reg.scl_low),
        .i_scl_high (r_reg.scl_s[1]),
        .i_reload   (i_baud_reload_reg),
        .o_tick     (tick),
        .o_stalled  (stalled)
    );

    always_comb
    begin
        r_next       = r_reg;
        r_next.irq   = 1'b0;
        r_next.scl_s = {r_reg.scl_s[0], i_bus_clock_line};
        r_next.sda_s = {r_reg.sda_s[0], i_bus_data_line};
        if (i_rx_read)
        begin
            r_next.rx_buffer_full = 1'b0;
        end
        unique case (r_reg.st)
            ims_pkg::ST_IDLE:
            begin
                r_next.ph   = ims_pkg::PH_RST;
                r_next.bitn = ims_pkg::BIT_RST;
                // Priority only matters if software breaks one-hot use or writes the control bits and transmit data in one cycle
                if (i_ctrl_we && i_ctrl_bits[0])
                begin
                    r_next.st      = ims_pkg::ST_START;
                    r_next.sda_low = 1'b1;
                end
                else if (i_ctrl_we && i_ctrl_bits[1])
                begin
                    r_next.st      = ims_pkg::ST_RESTART;
                    r_next.scl_low = 1'b1;
                    r_next.sda_low = 1'b0;
                end
                else if (i_ctrl_we && i_ctrl_bits[2])
                begin
                    r_next.st      = ims_pkg::ST_STOP;
                    r_next.scl_low = 1'b1;
                    r_next.sda_low = 1'b1;
                end
                else if (i_ctrl_we && i_ctrl_bits[3])
                begin
                    r_next.st      = ims_pkg::ST_RX;
                    r_next.scl_low = 1'b1;
                    r_next.sda_low = 1'b0;
                end
                else if (i_ctrl_we && i_ctrl_bits[4])
                begin
                    r_next.st      = ims_pkg::ST_ACK;
                    r_next.scl_low = 1'b1;
                    r_next.sda_low = !i_ack_level_select;
                end
                else if (i_tx_we)
                begin
                    r_next.st      = ims_pkg::ST_TX;
                    r_next.shift   = i_tx_data_reg;
                    r_next.scl_low = 1'b1;
                    r_next.sda_low = !i_tx_data_reg[7];
                end
            end
            ims_pkg::ST_START:
            begin
                if (tick)
                begin
                    r_next.ph = r_reg.ph + 2'h1;
                    if (r_reg.ph != PH_ONE)
                    begin
                        r_next.scl_low = 1'b1;
                    end
                    else
                    begin
                        r_next.st  = ims_pkg::ST_IDLE;
                        r_next.irq = 1'b1;
                    end
                end
            end
            ims_pkg::ST_RESTART,
            ims_pkg::ST_STOP:
            begin
                if (tick)
                begin
                    r_next.ph = r_reg.ph + 2'h1;
                    unique case (r_reg.ph)
                        2'h0:    r_next.scl_low = 1'b0;
                        2'h1:    r_next.sda_low =
                                     (r_reg.st == ims_pkg::ST_RESTART);
                        default:
                        begin
                            r_next.scl_low = (r_reg.st == ims_pkg::ST_RESTART);
                            r_next.st      = ims_pkg::ST_IDLE;
                            r_next.irq     = 1'b1;
                        end
                    endcase
                end
            end
            ims_pkg::ST_TX,
            ims_pkg::ST_RX,
            ims_pkg::ST_ACK:
            begin
                if (tick && r_reg.ph == ims_pkg::PH_RST)
                begin
                    r_next.ph      = PH_ONE;
                    r_next.scl_low = 1'b0;
                end
                else if (tick)
                begin
                    // Data sampled at the end of the high half
                    r_next.ph      = ims_pkg::PH_RST;
                    r_next.scl_low = 1'b1;
                    r_next.bitn    = r_reg.bitn + 4'h1;
                    r_next.shift   = {r_reg.shift[6:0], r_reg.sda_s[1]};
                    if (r_reg.st == ims_pkg::ST_ACK)
                    begin
                        r_next.st  = ims_pkg::ST_IDLE;
                        r_next.irq = 1'b1;
                    end
                    else if (r_reg.st == ims_pkg::ST_RX)
                    begin
                        if (r_reg.bitn == ims_pkg::RX_LAST_BIT)
                        begin
                            r_next.rx  = r_next.shift;
                            r_next.rx_buffer_full = 1'b1;
                            r_next.st  = ims_pkg::ST_IDLE;
                            r_next.irq = 1'b1;
                        end
                    end
                    else if (r_reg.bitn == ims_pkg::TX_LAST_BIT)
                    begin
                        r_next.ackd = !r_reg.sda_s[1];
                        r_next.st   = ims_pkg::ST_IDLE;
                        r_next.irq  = 1'b1;
                    end
                    else
                    begin
                        // Drive the next data bit, or release data for the acknowledge slot after bit 7
                        r_next.sda_low =
                            (r_reg.bitn != RX_BIT7) && !r_reg.shift[6];
                    end
                end
            end
            default:
            begin
                r_next.st = ims_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r_reg <= '{st: ims_pkg::ST_IDLE, ph: ims_pkg::PH_RST,
                       bitn: ims_pkg::BIT_RST, shift: ims_pkg::DATA_RST,
                       rx: ims_pkg::DATA_RST, rx_buffer_full: 1'b0, irq: 1'b0,
                       ackd: 1'b0, scl_low: 1'b0, sda_low: 1'b0,
                       scl_s: ims_pkg::SYNC_RST, sda_s: ims_pkg::SYNC_RST};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign o_control_bits     = ev_code(r_reg.st);
    assign o_master_tx_active = (r_reg.st == ims_pkg::ST_TX);
    assign o_rx_data_reg      = r_reg.rx;
    assign o_rx_buffer_full   = r_reg.rx_buffer_full;
    assign o_ack_received     = r_reg.ackd;
    assign o_master_event_irq = r_reg.irq;
    assign o_bus_clock_line   = 1'b0;
    assign o_bus_clock_oe     = r_reg.scl_low;
    assign o_bus_data_line    = 1'b0;
    assign o_bus_data_oe      = r_reg.sda_low;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    a_idle_bits_zero: assert property (
        r_reg.st == ims_pkg::ST_IDLE |-> o_control_bits == ims_pkg::EV_NONE)
        else $error("event bits set while idle");

    a_tx_flag: assert property (
        o_master_tx_active |-> o_control_bits == ims_pkg::EV_NONE
        && r_reg.st == ims_pkg::ST_TX)
        else $error("transmit flag wrong");

    a_onehot_code: assert property ($onehot0(o_control_bits))
        else $error("event bits not one-hot");

    a_done_irq: assert property (
        r_reg.st != ims_pkg::ST_IDLE ##1 r_reg.st == ims_pkg::ST_IDLE
        |-> o_master_event_irq)
        else $error("no interrupt at event end");

    a_tx_launch: assert property (
        r_reg.st == ims_pkg::ST_IDLE && i_tx_we && !i_ctrl_we
        |=> o_master_tx_active && o_bus_clock_oe
        && o_bus_data_oe == !$past(i_tx_data_reg[7]))
        else $error("transmit not launched");

    a_rx_launch: assert property (
        r_reg.st == ims_pkg::ST_IDLE && i_ctrl_we
        && i_ctrl_bits == ims_pkg::EV_RECEIVE
        |=> o_control_bits == ims_pkg::EV_RECEIVE)
        else $error("receive not launched");

    a_rbf_clear: assert property (
        i_rx_read && !(r_reg.st == ims_pkg::ST_RX && tick
        && r_reg.ph == PH_ONE && r_reg.bitn == RX_BIT7)
        |=> !o_rx_buffer_full)
        else $error("buffer-full not cleared by read");

    a_busy_ignore: assert property (
        r_reg.st != ims_pkg::ST_IDLE && i_ctrl_we
        |=> o_control_bits == $past(o_control_bits)
        || o_control_bits == ims_pkg::EV_NONE)
        else $error("write accepted while busy");

    a_stall_release: assert property (
        stalled |-> !o_bus_clock_oe)
        else $error("clock driven while counter held");

endmodule : ims_master

// >>> tb/ims_bus_partner.sv
/*
 * Behavioural slave on the two-wire bus: stretches the clock after
 * each falling edge, answers acknowledge, returns a byte on reads.
 * Assumes the bench resolves the wired lines with pull-ups.
 */
`timescale 1ns/1ps
module ims_bus_partner (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    // Wired bus levels
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    // Behaviour chosen by the bench
    input  wire logic [3:0] i_stretch,
    input  wire logic       i_read,
    input  wire logic       i_ack_en,
    input  wire logic [7:0] i_byte,
    // Pin drives and capture
    output logic            o_scl_oe,
    output logic            o_sda_oe,
    output logic [7:0]      o_rx_byte
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] slot;
    logic [3:0] hold;

    // Slot 4'hF: between a start and its first clock fall
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            slot      <= 4'hF;
            hold      <= 4'h0;
            o_rx_byte <= 8'h00;
        end
        else
        begin
            scl_q <= i_scl;
            sda_q <= i_sda;
            if (hold != 4'h0)
                hold <= hold - 4'h1;
            if (scl_q && i_scl && sda_q && !i_sda)
                slot <= 4'hF;
            else if (scl_q && !i_scl)
            begin
                slot <= (slot >= 4'h8) ? 4'h0 : slot + 4'h1;
                hold <= i_stretch;
            end
            else if (!scl_q && i_scl && slot < 4'h8 && !i_read)
                o_rx_byte <= {o_rx_byte[6:0], i_sda};
        end
    end

    // Data changes only while the clock is low, one cycle after a fall
    assign o_scl_oe = (hold != 4'h0);
    assign o_sda_oe = i_read ? (slot < 4'h8 && !i_byte[3'h7 - slot[2:0]])
                             : (slot == 4'h8 && i_ack_en);
endmodule : ims_bus_partner

// >>> tb/i2c_master_sequencing_clock_sync_tb_top.sv
/*
 * Self-checking bench of the bus master: whole write and read messages
 * against a stretching slave model, random bytes and baud values.
 * Assumes open-drain lines with pull-ups, resolved here.
 */
`timescale 1ns/1ps
module i2c_master_sequencing_clock_sync_tb_top;
    logic        i_mclk;
    logic        i_rst_n;
    logic        ctrl_we;
    logic [4:0]  ctrl_bits;
    logic        ack_lvl;
    logic [11:0] baud;
    logic        tx_we;
    logic [7:0]  tx_data;
    logic        rx_read;
    logic [4:0]  ctrl;
    logic        tx_act;
    logic [7:0]  rx_data;
    logic        rx_full;
    logic        ack_rx;
    logic        irq;
    logic        m_scl_oe;
    logic        m_sda_oe;
    logic        p_scl_oe;
    logic        p_sda_oe;
    logic        m_scl_o;
    logic        m_sda_o;
    logic [7:0]  p_rx;
    logic [3:0]  p_stretch;
    logic        p_read;
    logic        p_ack;
    logic [7:0]  p_byte;
    logic        scl_w;
    logic        sda_w;
    logic        rel = 1'b0;
    logic        oe_q = 1'b0;
    logic        scl_q = 1'b1;
    int          hi_cnt = 0;
    int          cyc_cnt = 0;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          seed = 13;

    // Pull-ups: a released line reads high
    assign scl_w = !(m_scl_oe | p_scl_oe);
    assign sda_w = !(m_sda_oe | p_sda_oe);

    ims_master uut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ctrl_we(ctrl_we),
        .i_ctrl_bits(ctrl_bits), .i_ack_level_select(ack_lvl),
        .i_baud_reload_reg(baud), .o_control_bits(ctrl),
        .o_master_tx_active(tx_act), .i_tx_we(tx_we),
        .i_tx_data_reg(tx_data), .i_rx_read(rx_read),
        .o_rx_data_reg(rx_data), .o_rx_buffer_full(rx_full),
        .o_ack_received(ack_rx), .o_master_event_irq(irq),
        .i_bus_clock_line(scl_w), .o_bus_clock_line(m_scl_o),
        .o_bus_clock_oe(m_scl_oe), .i_bus_data_line(sda_w),
        .o_bus_data_line(m_sda_o), .o_bus_data_oe(m_sda_oe)
    );

    ims_bus_partner slave (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl_w), .i_sda(sda_w),
        .i_stretch(p_stretch), .i_read(p_read), .i_ack_en(p_ack),
        .i_byte(p_byte), .o_scl_oe(p_scl_oe), .o_sda_oe(p_sda_oe),
        .o_rx_byte(p_rx)
    );

    initial
    begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    task automatic step;
        @(posedge i_mclk);
        #1;
    endtask : step

    task automatic wait_irq;
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 4000)
        begin
            step();
            k++;
        end
        check("irq", irq, 1'b1);
        check("ctrl_end", ctrl, ims_pkg::EV_NONE);
        step();
        check("irq_pulse", irq, 1'b0);
    endtask : wait_irq

    // Second write lands while busy and must be dropped
    task automatic do_ev(input logic [4:0] c);
        step();
        ctrl_we = 1'b1;
        ctrl_bits = c;
        step();
        check("ctrl", ctrl, c);
        ctrl_bits = 5'h1F;
        tx_we = 1'b1;
        step();
        ctrl_we = 1'b0;
        tx_we = 1'b0;
        check("ctrl_busy", ctrl, c);
        check("tx_busy", tx_act, 1'b0);
        wait_irq();
    endtask : do_ev

    task automatic tx(input logic [7:0] b, input logic ack);
        step();
        tx_we = 1'b1;
        tx_data = b;
        step();
        tx_we = 1'b0;
        check("tx_active", tx_act, 1'b1);
        check("ctrl_tx", ctrl, ims_pkg::EV_NONE);
        wait_irq();
        check("tx_done", tx_act, 1'b0);
        check("ack_seen", ack_rx, ack);
        check("slave_byte", p_rx, b);
    endtask : tx

    task automatic rx(input logic lvl);
        logic [7:0] b;
        b = 8'($random(seed));
        p_byte = b;
        ack_lvl = lvl;
        do_ev(ims_pkg::EV_RECEIVE);
        check("rx_data", rx_data, b);
        check("rx_full", rx_full, 1'b1);
        do_ev(ims_pkg::EV_ACK);
        check("ack_drive", m_sda_oe, !lvl);
        step();
        rx_read = 1'b1;
        step();
        rx_read = 1'b0;
        check("rx_cleared", rx_full, 1'b0);
    endtask : rx

    // Events only when idle; address first, direction bit set for reads
    task automatic msg(input logic [3:0] st);
        logic [6:0] a;
        a = 7'($random(seed));
        p_stretch = st;
        p_ack = 1'b1;
        baud = 12'h006 + {8'h00, 3'($random(seed)), 1'b0};
        do_ev(ims_pkg::EV_START);
        tx({a, 1'b0}, 1'b1);
        tx(8'($random(seed)), 1'b1);
        p_ack = 1'b0;
        tx(8'($random(seed)), 1'b0);
        p_ack = 1'b1;
        do_ev(ims_pkg::EV_RESTART);
        tx({a, 1'b1}, 1'b1);
        p_read = 1'b1;
        rx(1'b0);
        rx(1'b1);
        p_read = 1'b0;
        do_ev(ims_pkg::EV_STOP);
    endtask : msg

    // Sampled on the falling edge, clear of the design's updates
    always @(negedge i_mclk)
    begin
        cyc_cnt++;
        if (cyc_cnt > 60000)
        begin
            error_cnt++;
            tally_and_finish();
        end
        if (i_rst_n && rel)
            check("scl_wait", m_scl_oe, 1'b0);
        if (i_rst_n && scl_q && !scl_w)
            check("scl_high", hi_cnt >= baud[11:1], 1'b1);
        hi_cnt = scl_w ? hi_cnt + 1 : 0;
        rel = (oe_q && !m_scl_oe) ? 1'b1 : (scl_w ? 1'b0 : rel);
        oe_q = m_scl_oe;
        scl_q = scl_w;
    end

    initial
    begin
        i_rst_n = 1'b0;
        ctrl_we = 1'b0;
        ctrl_bits = 5'h00;
        ack_lvl = 1'b0;
        baud = 12'h008;
        tx_we = 1'b0;
        tx_data = 8'h00;
        rx_read = 1'b0;
        p_stretch = 4'h0;
        p_read = 1'b0;
        p_ack = 1'b1;
        p_byte = 8'h00;
        repeat (8) @(posedge i_mclk);
        #1;
        i_rst_n = 1'b1;
        check("ctrl_rst", ctrl, ims_pkg::EV_NONE);
        check("tx_rst", tx_act, 1'b0);
        check("pin_level", {m_scl_o, m_sda_o}, 2'h0);
        msg(4'h0);
        msg(4'($random(seed)) | 4'h4);
        msg(4'h9);
        tally_and_finish();
    end
endmodule : i2c_master_sequencing_clock_sync_tb_top
